// >>> osdrh_pkg.sv
// Shared types and constants for the overlay row height and character attribute block
package osdrh_pkg;

  // Row attribute word, the invisible first column of each display RAM row
  typedef struct packed {
    logic backIntense;
    logic [3:0] rowSpacing;
    logic [3:0] heightStretch;
    logic doubleHeightBit;
    logic doubleWidthBit;
    logic [3:0] shadowMode;
    logic lastRowFlag;
  } osdrh_row_attr_t;

  // Character code word: font address and character attribute
  typedef struct packed {
    logic [7:0] fontAddr;
    logic [2:0] bgRgb;
    logic [3:0] fgRgbi;
    logic blink;
  } osdrh_char_word_t;

  typedef struct packed {
    logic opaque;
    logic [3:0] rgbi;
  } osdrh_pixel_t;

  typedef enum logic [1:0] {GLYPH_NORMAL, GLYPH_MULTI, GLYPH_SPACE} osdrh_glyph_t;
  typedef enum logic [1:0] {ROW_IDLE, ROW_LINES, ROW_SPACING} osdrh_row_state_t;

  localparam int unsigned FONT_ADDR_W = 13;
  localparam logic [4:0] FONT_WORDS = 5'h14;
  localparam logic [7:0] SPACE_CODE = 8'hFF;
  localparam logic [3:0] FIRST_INSERT_CODE = 4'h4;
  localparam logic [5:0] LINES_FULL = 6'h12;
  localparam logic [5:0] LINES_THREE_QUARTER = 6'h0D;
  localparam logic [5:0] LINES_HALF = 6'h09;
  localparam logic [5:0] LINES_QUARTER = 6'h05;

  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_GFX_START = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_SPACE_COLOUR = 4'h3;
  localparam int unsigned CTRL_BLINK_RATE_BIT = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] GFX_START_RESET = 8'hC0;
  localparam logic [3:0] SPACE_COLOUR_RESET = 4'h0;

  localparam int unsigned BLINK_FAST_FRAMES = 16;
  localparam int unsigned BLINK_SLOW_FRAMES = 32;

endpackage

// >>> osdrh_row_height.sv
// Overlay row height stretching, row spacing and character attribute decoding
//
// Behaviour
// - Stretch code from row attribute bits 10..7
// - Code n adds n lines, 2n double
// - Repeat exactly the lines mapped per code
// - Same repetition for every character in row
// - Row heights from 5 to 66 lines
// - Spacing code from row attribute bits 14..11
// - Spacing codes 1..3 show upper row part
// - Spacing codes 4..15 insert blank lines
// - Window and fade stay on spacing lines
// - Row bit 15 intensifies background colour
// - Font address from character bits 15..8
// - Each font spans twenty twelve-bit words
// - Normal glyph background and foreground colours
// - Attribute bit 0 blinks, rate by control
// - Above graphic start: three-plane multicolour glyph
// - Font address FFH is the space code
// - Multicolour: bit 1 fills 000b dots
// - Multicolour dots blink, background stays steady
// - Row attribute read from first column
// - Row bit 6 doubles the row height
`timescale 1ns/1ps
module osdrh_row_height #(
  parameter int unsigned BLINK_FAST = osdrh_pkg::BLINK_FAST_FRAMES,
  parameter int unsigned BLINK_SLOW = osdrh_pkg::BLINK_SLOW_FRAMES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  input wire logic rowAttrValid,
  input wire osdrh_pkg::osdrh_row_attr_t rowAttr,
  input wire logic lineStrobe,
  input wire logic frameStrobe,
  output logic rowBusy,
  output logic rowDone,
  output logic spacingLine,
  output logic effectsEnable,
  output logic doubleWidth,
  output logic [4:0] rowFontWord,
  input wire logic charLoad,
  input wire osdrh_pkg::osdrh_char_word_t charWord,
  output osdrh_pkg::osdrh_glyph_t glyphKind,
  output logic [osdrh_pkg::FONT_ADDR_W-1:0] fontWordAddr [3],
  input wire logic dotValid,
  input wire logic normDot,
  input wire logic [2:0] multiDot,
  output logic pixValid,
  output osdrh_pkg::osdrh_pixel_t pixel
);

  // Line index counts in the doubled space when the row is double height
  function automatic logic lineRepeats(input logic [5:0] idx, input logic dbl,
                                       input logic [3:0] code);
    logic r;
    r = 1'b0;
    if (!dbl) begin
      r = (code[0] && idx == 6'h09)
        || (code[1] && idx[2:0] == 3'h5 && idx <= 6'h0D)
        || (code[2] && idx[1:0] == 2'h3 && idx <= 6'h0F)
        || (code[3] && !idx[0] && idx >= 6'h02 && idx <= 6'h10);
    end else begin
      r = (code[0] && (idx == 6'h13 || idx == 6'h14))
        || (code[1] && (idx[3:0] == 4'hB || idx[3:0] == 4'hC) && idx <= 6'h1C)
        || (code[2] && (idx[2:0] == 3'h7 || (idx[2:0] == 3'h0 && idx != 6'h00))
            && idx <= 6'h20)
        || (code[3] && (idx[1:0] == 2'h1 || idx[1:0] == 2'h2)
            && idx >= 6'h05 && idx <= 6'h22);
    end
    return r;
  endfunction

  function automatic logic [5:0] lastLine(input logic dbl, input logic [3:0] spacing);
    logic [5:0] n;
    n = osdrh_pkg::LINES_FULL;
    unique case (spacing)
      4'h0: n = osdrh_pkg::LINES_FULL;
      4'h1: n = osdrh_pkg::LINES_THREE_QUARTER;
      4'h2: n = osdrh_pkg::LINES_HALF;
      4'h3: n = osdrh_pkg::LINES_QUARTER;
      default: n = osdrh_pkg::LINES_FULL;
    endcase
    if (dbl) begin
      n = {n[4:0], 1'b0};
    end
    return n - 6'h01;
  endfunction

  function automatic logic [osdrh_pkg::FONT_ADDR_W-1:0] wordAddr(input logic [7:0] font,
      input logic [1:0] plane, input logic [4:0] word);
    logic [osdrh_pkg::FONT_ADDR_W-1:0] base;
    base = osdrh_pkg::FONT_ADDR_W'(font) + osdrh_pkg::FONT_ADDR_W'(plane);
    return osdrh_pkg::FONT_ADDR_W'(base * osdrh_pkg::FONT_ADDR_W'(osdrh_pkg::FONT_WORDS))
      + osdrh_pkg::FONT_ADDR_W'(word);
  endfunction

  osdrh_pkg::osdrh_row_state_t rowState_q;
  osdrh_pkg::osdrh_row_attr_t attr_q;
  osdrh_pkg::osdrh_char_word_t char_q;
  logic [5:0] lineIdx_q;
  logic repeatDone_q;
  logic [3:0] spaceCnt_q;
  logic rowDone_q;
  logic [7:0] control_q;
  logic [7:0] gfxStart_q;
  logic [3:0] spaceColour_q;
  logic [15:0] rdData_q;
  logic [5:0] blinkCnt_q;
  logic blinkOff_q;
  logic pixValid_q;
  osdrh_pkg::osdrh_pixel_t pixel_q;
  osdrh_pkg::osdrh_glyph_t kind_q;
  logic [osdrh_pkg::FONT_ADDR_W-1:0] addr_q [3];

  logic [5:0] fontLine;
  logic [5:0] blinkLast;
  logic inRowLines;

  logic takeRow;
  logic lineStep;
  logic repeatHit;
  logic lastHit;
  logic toSpacing;
  logic spaceStep;
  logic spacingEnd;

  assign inRowLines = rowState_q == osdrh_pkg::ROW_LINES;
  // Double height shows each font line on two consecutive scan lines
  assign fontLine = attr_q.doubleHeightBit ? {1'b0, lineIdx_q[5:1]} : lineIdx_q;
  // Word 0 of each font holds the previous row, so visible lines start at word 1
  assign rowFontWord = fontLine[4:0] + 5'h01;
  assign blinkLast = control_q[osdrh_pkg::CTRL_BLINK_RATE_BIT]
    ? 6'(BLINK_SLOW - 1) : 6'(BLINK_FAST - 1);

  // Row sequencer
  assign takeRow = rowState_q == osdrh_pkg::ROW_IDLE && rowAttrValid;
  assign lineStep = inRowLines && lineStrobe;
  assign repeatHit = lineStep && !repeatDone_q
    && lineRepeats(lineIdx_q, attr_q.doubleHeightBit, attr_q.heightStretch);
  assign lastHit = lineStep && !repeatHit
    && lineIdx_q == lastLine(attr_q.doubleHeightBit, attr_q.rowSpacing);
  assign toSpacing = lastHit && attr_q.rowSpacing >= osdrh_pkg::FIRST_INSERT_CODE;
  assign spaceStep = spacingLine && lineStrobe;
  assign spacingEnd = spaceStep && spaceCnt_q == 4'h1;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rowState_q <= osdrh_pkg::ROW_IDLE;
    end else begin
      unique case (rowState_q)
        osdrh_pkg::ROW_IDLE: begin
          if (takeRow) begin
            rowState_q <= osdrh_pkg::ROW_LINES;
          end
        end
        osdrh_pkg::ROW_LINES: begin
          if (toSpacing) begin
            rowState_q <= osdrh_pkg::ROW_SPACING;
          end else if (lastHit) begin
            rowState_q <= osdrh_pkg::ROW_IDLE;
          end
        end
        osdrh_pkg::ROW_SPACING: begin
          if (spacingEnd) begin
            rowState_q <= osdrh_pkg::ROW_IDLE;
          end
        end
        default: rowState_q <= osdrh_pkg::ROW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      attr_q <= '0;
    end else if (takeRow) begin
      attr_q <= rowAttr;
    end
  end

  // Original line index; a repeat holds it one more line
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lineIdx_q <= 6'h00;
    end else if (takeRow) begin
      lineIdx_q <= 6'h00;
    end else if (lineStep && !repeatHit && !lastHit) begin
      lineIdx_q <= lineIdx_q + 6'h01;
    end
  end

  // Mapped lines shown twice, copy right after original
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      repeatDone_q <= 1'b0;
    end else if (takeRow) begin
      repeatDone_q <= 1'b0;
    end else if (repeatHit) begin
      repeatDone_q <= 1'b1;
    end else if (lineStep) begin
      repeatDone_q <= 1'b0;
    end
  end

  // Blank lines inserted after the visible part
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spaceCnt_q <= 4'h0;
    end else if (toSpacing) begin
      spaceCnt_q <= attr_q.rowSpacing;
    end else if (spaceStep && !spacingEnd) begin
      spaceCnt_q <= spaceCnt_q - 4'h1;
    end
  end

  // One-cycle pulse after the final line of a row
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rowDone_q <= 1'b0;
    end else begin
      rowDone_q <= (lastHit && !toSpacing) || spacingEnd;
    end
  end

  assign rowBusy = rowState_q != osdrh_pkg::ROW_IDLE;
  assign rowDone = rowDone_q;
  assign spacingLine = rowState_q == osdrh_pkg::ROW_SPACING;
  assign effectsEnable = rowBusy;
  assign doubleWidth = attr_q.doubleWidthBit;

  // Register port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_q <= osdrh_pkg::CONTROL_RESET;
    end else if (regWrStb && regAddr == osdrh_pkg::REG_CONTROL) begin
      control_q <= regWrData[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gfxStart_q <= osdrh_pkg::GFX_START_RESET;
    end else if (regWrStb && regAddr == osdrh_pkg::REG_GFX_START) begin
      gfxStart_q <= regWrData[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 16'h0000;
    end else if (regRdStb) begin
      unique case (regAddr)
        osdrh_pkg::REG_CONTROL: rdData_q <= {8'h00, control_q};
        osdrh_pkg::REG_GFX_START: rdData_q <= {8'h00, gfxStart_q};
        osdrh_pkg::REG_STATUS: rdData_q <= {5'h00, rowState_q, repeatDone_q, spaceCnt_q,
                                             lineIdx_q[3:0]};
        osdrh_pkg::REG_SPACE_COLOUR: rdData_q <= {12'h000, spaceColour_q};
        default: rdData_q <= 16'h0000;
      endcase
    end else begin
      rdData_q <= 16'h0000;
    end
  end

  assign regRdData = rdData_q;

  // Blink phase from frame count
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blinkCnt_q <= 6'h00;
      blinkOff_q <= 1'b0;
    end else if (frameStrobe) begin
      if (blinkCnt_q >= blinkLast) begin
        blinkCnt_q <= 6'h00;
        blinkOff_q <= !blinkOff_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 6'h01;
      end
    end
  end

  // Character load: classify and form font memory word addresses
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      char_q <= '0;
    end else if (charLoad) begin
      char_q <= charWord;
    end
  end

  // Three planes on consecutive font sites
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < 3; p++) begin
        addr_q[p] <= '0;
      end
    end else if (charLoad) begin
      for (int p = 0; p < 3; p++) begin
        addr_q[p] <= wordAddr(charWord.fontAddr, 2'(p), rowFontWord);
      end
    end
  end

  // Glyph class of the latest character
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      kind_q <= osdrh_pkg::GLYPH_NORMAL;
    end else if (charLoad) begin
      if (charWord.fontAddr == osdrh_pkg::SPACE_CODE) begin
        kind_q <= osdrh_pkg::GLYPH_SPACE;
      end else if (charWord.fontAddr > gfxStart_q) begin
        kind_q <= osdrh_pkg::GLYPH_MULTI;
      end else begin
        kind_q <= osdrh_pkg::GLYPH_NORMAL;
      end
    end
  end

  // Colour of the last space code, reused under multicolour dots
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spaceColour_q <= osdrh_pkg::SPACE_COLOUR_RESET;
    end else if (charLoad && charWord.fontAddr == osdrh_pkg::SPACE_CODE) begin
      spaceColour_q <= charWord.fgRgbi;
    end
  end

  assign glyphKind = kind_q;
  assign fontWordAddr = addr_q;

  // Dot colouring
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pixValid_q <= 1'b0;
      pixel_q <= '0;
    end else begin
      pixValid_q <= dotValid;
      if (dotValid) begin
        if (!inRowLines) begin
          pixel_q <= '0;
        end else begin
          unique case (kind_q)
            osdrh_pkg::GLYPH_NORMAL: begin
              if (normDot && !(char_q.blink && blinkOff_q)) begin
                pixel_q <= {1'b1, char_q.fgRgbi};
              end else begin
                pixel_q <= {1'b1, char_q.bgRgb, attr_q.backIntense};
              end
            end
            osdrh_pkg::GLYPH_MULTI: begin
              if (multiDot != 3'h0 && !(char_q.blink && blinkOff_q)) begin
                pixel_q <= {1'b1, multiDot, 1'b0};
              end else if (char_q.fgRgbi[0]) begin
                pixel_q <= {1'b1, spaceColour_q};
              end else begin
                pixel_q <= '0;
              end
            end
            default: pixel_q <= '0;
          endcase
        end
      end
    end
  end

  assign pixValid = pixValid_q;
  assign pixel = pixel_q;

endmodule

// >>> osdrh_row_height_checker.sv
// Port assertions for the overlay row height block
`timescale 1ns/1ps
module osdrh_row_height_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic rowAttrValid,
  input wire logic rowBusy,
  input wire logic rowDone,
  input wire logic spacingLine,
  input wire logic effectsEnable,
  input wire logic [4:0] rowFontWord,
  input wire logic charLoad,
  input wire osdrh_pkg::osdrh_char_word_t charWord,
  input wire osdrh_pkg::osdrh_glyph_t glyphKind,
  input wire logic [osdrh_pkg::FONT_ADDR_W-1:0] fontWordAddr [3],
  input wire logic dotValid,
  input wire logic pixValid,
  input wire osdrh_pkg::osdrh_pixel_t pixel
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_row_start: assert property (rowAttrValid && !rowBusy |=> rowBusy)
    else $error("row did not start");
  a_done_pulse: assert property ($rose(rowDone) |=> !rowDone && rowBusy == $past(rowAttrValid))
    else $error("row done not a single pulse");
  a_spacing_busy: assert property (spacingLine |-> rowBusy)
    else $error("spacing line outside a row");
  a_effects_on: assert property (effectsEnable == rowBusy)
    else $error("effects enable differs from row busy");
  a_word_range: assert property (rowBusy |-> rowFontWord inside {[5'h01:5'h12]})
    else $error("font word outside visible rows");
  a_pix_delay: assert property (1'b1 |=> pixValid == $past(dotValid))
    else $error("pixel valid not one cycle after dot");
  a_blank_dots: assert property (dotValid && (spacingLine || !rowBusy) |=> pixel == '0)
    else $error("dot drawn outside row lines");
  a_space_kind: assert property (charLoad && charWord.fontAddr == osdrh_pkg::SPACE_CODE
    |=> glyphKind == osdrh_pkg::GLYPH_SPACE)
    else $error("space code not decoded");
  a_plane_addr: assert property (charLoad |=> fontWordAddr[1] ==
    (13'($past(charWord.fontAddr)) + 13'h0001) * 13'h0014 + 13'($past(rowFontWord)))
    else $error("second plane address wrong");
endmodule
bind osdrh_row_height osdrh_row_height_checker u_chk (.clock(clock), .resetn(resetn),
  .rowAttrValid(rowAttrValid), .rowBusy(rowBusy), .rowDone(rowDone),
  .spacingLine(spacingLine), .effectsEnable(effectsEnable), .rowFontWord(rowFontWord),
  .charLoad(charLoad), .charWord(charWord), .glyphKind(glyphKind),
  .fontWordAddr(fontWordAddr), .dotValid(dotValid), .pixValid(pixValid), .pixel(pixel));

// >>> osdrh_host_model.sv
// Host controller model driving the overlay register port
`timescale 1ns/1ps
module osdrh_host_model (
  input wire logic clock,
  output logic [3:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    regAddr <= ~a;
    @(posedge clock);
    d = regRdData;
  endtask
endmodule

// >>> osd_row_height_and_char_attr_test.sv
// Self-checking bench for the overlay row height block
`timescale 1ns/1ps
module osd_row_height_and_char_attr_test;
  logic clock, resetn, regWrStb, regRdStb, rowAttrValid, lineStrobe, frameStrobe;
  logic rowBusy, rowDone, spacingLine, effectsEnable, doubleWidth, charLoad;
  logic dotValid, normDot, pixValid;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, rd;
  logic [4:0] rowFontWord;
  logic [2:0] multiDot;
  logic [osdrh_pkg::FONT_ADDR_W-1:0] fontWordAddr [3];
  osdrh_pkg::osdrh_row_attr_t rowAttr;
  osdrh_pkg::osdrh_char_word_t charWord;
  osdrh_pkg::osdrh_glyph_t glyphKind;
  osdrh_pkg::osdrh_pixel_t pixel;
  int errors = 0;
  int n_tests = 0;
  logic [15:0] attrs [7] = '{16'h0100, 16'h07C0, 16'h1800, 16'h0840, 16'h2000, 16'h7800, 16'h0020};
  int expLines [7] = '{20, 66, 5, 26, 22, 33, 18};
  int expSpace [7] = '{0, 0, 0, 0, 4, 15, 0};
  osdrh_row_height #(.BLINK_FAST(2), .BLINK_SLOW(4)) DUT (.clock(clock), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rowAttrValid(rowAttrValid), .rowAttr(rowAttr),
    .lineStrobe(lineStrobe), .frameStrobe(frameStrobe), .rowBusy(rowBusy), .rowDone(rowDone),
    .spacingLine(spacingLine), .effectsEnable(effectsEnable), .doubleWidth(doubleWidth),
    .rowFontWord(rowFontWord), .charLoad(charLoad), .charWord(charWord),
    .glyphKind(glyphKind), .fontWordAddr(fontWordAddr), .dotValid(dotValid),
    .normDot(normDot), .multiDot(multiDot), .pixValid(pixValid), .pixel(pixel));
  osdrh_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic start_row(input logic [15:0] a);
    @(posedge clock);
    rowAttrValid <= 1'b1;
    rowAttr <= a;
    @(posedge clock);
    rowAttrValid <= 1'b0;
  endtask
  task automatic finish_row(input int el, input int es);
    int nl = 0;
    int ns = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clock);
      if (rowDone === 1'b1) break;
      lineStrobe <= 1'b1;
      nl++;
      ns += int'(spacingLine === 1'b1);
      @(posedge clock);
      lineStrobe <= 1'b0;
    end
    check("row lines", 16'(nl), 16'(el));
    check("spacing lines", 16'(ns), 16'(es));
  endtask
  task automatic dot(input logic [15:0] cw, input logic nd, input logic [2:0] md,
                     input logic [4:0] exp, input osdrh_pkg::osdrh_glyph_t kind);
    @(posedge clock);
    charLoad <= 1'b1;
    charWord <= cw;
    @(posedge clock);
    charLoad <= 1'b0;
    dotValid <= 1'b1;
    normDot <= nd;
    multiDot <= md;
    @(posedge clock);
    dotValid <= 1'b0;
    @(posedge clock);
    check("pixel", 16'(pixel), 16'(exp));
    check("pixel valid", 16'(pixValid), 16'h0001);
    check("glyph kind", 16'(glyphKind), 16'(kind));
  endtask
  initial begin
    #20000;
    errors++;
    final_report();
  end
  initial begin
    {resetn, rowAttrValid, lineStrobe, frameStrobe, charLoad, dotValid, normDot} = 7'h00;
    rowAttr = 16'h0000;
    charWord = 16'h0000;
    multiDot = 3'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    host.rd(osdrh_pkg::REG_GFX_START, rd);
    check("graphic start", rd, 16'h00C0);
    host.wr(osdrh_pkg::REG_CONTROL, 16'hFF04);
    host.rd(osdrh_pkg::REG_CONTROL, rd);
    check("control", rd, 16'h0004);
    host.wr(osdrh_pkg::REG_CONTROL, 16'h0000);
    host.rd(4'hF, rd);
    check("unmapped", rd, 16'h0000);
    dot(16'h10B4, 1'b1, 3'h0, 5'h00, osdrh_pkg::GLYPH_NORMAL);
    start_row(16'h8080);
    dot(16'h10B4, 1'b1, 3'h0, 5'h1A, osdrh_pkg::GLYPH_NORMAL);
    dot(16'h10B4, 1'b0, 3'h0, 5'h1B, osdrh_pkg::GLYPH_NORMAL);
    dot(16'hFF0C, 1'b1, 3'h0, 5'h00, osdrh_pkg::GLYPH_SPACE);
    host.rd(osdrh_pkg::REG_SPACE_COLOUR, rd);
    check("space colour", rd, 16'h0006);
    dot(16'hC100, 1'b0, 3'h4, 5'h18, osdrh_pkg::GLYPH_MULTI);
    check("plane 0 address", 16'(fontWordAddr[0]), 16'h0F15);
    check("plane 2 address", 16'(fontWordAddr[2]), 16'h0F3D);
    dot(16'hC102, 1'b0, 3'h0, 5'h16, osdrh_pkg::GLYPH_MULTI);
    dot(16'hC100, 1'b0, 3'h0, 5'h00, osdrh_pkg::GLYPH_MULTI);
    dot(16'hC0B4, 1'b1, 3'h0, 5'h1A, osdrh_pkg::GLYPH_NORMAL);
    repeat (2) begin
      @(posedge clock) frameStrobe <= 1'b1;
      @(posedge clock) frameStrobe <= 1'b0;
    end
    dot(16'h10B5, 1'b1, 3'h0, 5'h1B, osdrh_pkg::GLYPH_NORMAL);
    dot(16'hC103, 1'b0, 3'h4, 5'h16, osdrh_pkg::GLYPH_MULTI);
    finish_row(19, 0);
    for (int k = 0; k < 7; k++) begin
      start_row(attrs[k]);
      finish_row(expLines[k], expSpace[k]);
      check("double width", 16'(doubleWidth), 16'(attrs[k][5]));
    end
    final_report();
  end
endmodule
